// ### rtl/dsfp_top.v
`timescale 1ns/1ns
`include "dsfp_regs.vh"
module dsfp_top #(
    parameter DEV_SEL = 1'b0
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire reset_n_i,
    // Avalon-MM slave
    input wire [5:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    // Stored security state
    input wire nv_lock_enabled_i,
    input wire hard_reset_i,
    output reg frozen_o,
    output reg lock_enabled_o,
    output reg locked_o,
    output reg level_max_o,
    output reg [15:0] master_rev_o,
    output reg [255:0] user_pw_o,
    output reg [255:0] master_pw_o,
    // Credential check for the unlock path
    input wire cred_check_i,
    input wire cred_sel_master_i,
    input wire [255:0] cred_pw_i,
    output reg cred_done_o,
    output reg cred_ok_o
);
    ////////////////////////////////////////////////////////////////////////////
    localparam ST_IDLE = 2'b00;
    localparam ST_XFER = 2'b01;
    localparam ST_EXEC = 2'b10;

    reg [1:0] state_q;
    reg [7:0] status_q;
    reg [7:0] error_q;
    reg [7:0] devh_q;
    reg user_valid_q;
    reg master_valid_q;
    reg por_done_q;

    wire [15:0] rx_ctrl;
    wire [255:0] rx_pw;
    wire [15:0] rx_rev;
    wire rx_done;
    wire cmp_match;

    ////////////////////////////////////////////////////////////////////////////
    // One wait state per access; effect lands on the acknowledge edge
    wire bus_req = avs_read_i | avs_write_i;
    wire wr_take = avs_write_i && !avs_waitrequest_o;
    wire wr_lo = avs_byteenable_i[0];
    wire wr_word = avs_byteenable_i[1] && avs_byteenable_i[0];
    wire data_wr = wr_take && wr_word && (avs_address_i == `DSFP_OFS_DATA) &&
        (state_q == ST_XFER);
    wire dev_hit = (devh_q[`DSFP_DEVH_DEV_BIT] == DEV_SEL);
    wire cmd_wr = wr_take && wr_lo && (avs_address_i == `DSFP_OFS_CMD) &&
        (state_q == ST_IDLE) && dev_hit;
    wire [7:0] opcode = avs_writedata_i[7:0];

    wire sel_master = rx_ctrl[`DSFP_CTL_SEL_BIT];
    wire sel_lvl_max = rx_ctrl[`DSFP_CTL_LVL_BIT];
    wire rev_ok = (rx_rev >= `DSFP_REV_MIN) && (rx_rev <= `DSFP_REV_MAX);

    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        case (avs_address_i)
            `DSFP_OFS_ERR: rd_mux = {24'h00_0000, error_q};
            `DSFP_OFS_DEVH: rd_mux = {24'h00_0000, devh_q};
            `DSFP_OFS_CMD: rd_mux = {24'h00_0000, status_q};
            `DSFP_OFS_SECST: rd_mux = {26'h000_0000, user_valid_q, master_valid_q,
                level_max_o, locked_o, lock_enabled_o, frozen_o};
            `DSFP_OFS_REV: rd_mux = {16'h0000, master_rev_o};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0000_0000;
        end else begin
            if (bus_req && avs_waitrequest_o) begin
                avs_waitrequest_o <= 1'b0;
                avs_readdata_o <= rd_mux;
            end else begin
                avs_waitrequest_o <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Device/head latch
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            devh_q <= 8'h00;
        end else if (wr_take && wr_lo && avs_address_i == `DSFP_OFS_DEVH) begin
            devh_q <= avs_writedata_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command engine
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            state_q <= ST_IDLE;
            status_q <= `DSFP_ST_RST;
            error_q <= `DSFP_ERR_NONE;
            frozen_o <= 1'b0;
            user_valid_q <= 1'b0;
            master_valid_q <= 1'b0;
            level_max_o <= 1'b0;
            master_rev_o <= `DSFP_REV_RST;
            user_pw_o <= 256'h0;
            master_pw_o <= 256'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (cmd_wr) begin
                        case (opcode)
                            `DSFP_OP_FREEZE: begin
                                frozen_o <= 1'b1;
                                status_q <= `DSFP_ST_OK;
                                error_q <= `DSFP_ERR_NONE;
                            end
                            `DSFP_OP_SETPW: begin
                                if (frozen_o || locked_o) begin
                                    status_q <= `DSFP_ST_ABORT;
                                    error_q <= `DSFP_ERR_ABT;
                                end else begin
                                    state_q <= ST_XFER;
                                    status_q <= `DSFP_ST_DRQ;
                                    error_q <= `DSFP_ERR_NONE;
                                end
                            end
                            // Rest of the security set, unlock included, is aborted
                            default: begin
                                status_q <= `DSFP_ST_ABORT;
                                error_q <= `DSFP_ERR_ABT;
                            end
                        endcase
                    end
                end
                ST_XFER: begin
                    if (rx_done) begin
                        state_q <= ST_EXEC;
                        status_q <= `DSFP_ST_BSY;
                    end
                end
                ST_EXEC: begin
                    state_q <= ST_IDLE;
                    status_q <= `DSFP_ST_OK;
                    error_q <= `DSFP_ERR_NONE;
                    if (sel_master) begin
                        master_pw_o <= rx_pw;
                        master_valid_q <= 1'b1;
                        if (rev_ok) begin
                            master_rev_o <= rx_rev;
                        end
                    end else begin
                        user_pw_o <= rx_pw;
                        user_valid_q <= 1'b1;
                        level_max_o <= sel_lvl_max;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lock enable and lock state; the strap is caught after release
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            por_done_q <= 1'b0;
            lock_enabled_o <= 1'b0;
            locked_o <= 1'b0;
        end else begin
            if (!por_done_q) begin
                por_done_q <= 1'b1;
                lock_enabled_o <= nv_lock_enabled_i;
                locked_o <= nv_lock_enabled_i;
            end else begin
                if (state_q == ST_EXEC && !sel_master) begin
                    lock_enabled_o <= 1'b1;
                end
                // Locking never follows from a master set alone
                if (hard_reset_i) begin
                    locked_o <= lock_enabled_o;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Credential check, one cycle
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            cred_done_o <= 1'b0;
            cred_ok_o <= 1'b0;
        end else begin
            cred_done_o <= cred_check_i;
            if (cred_check_i) begin
                cred_ok_o <= cmp_match;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    dsfp_sector_rx u_rx (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .active_i(state_q == ST_XFER),
        .wr_i(data_wr),
        .data_i(avs_writedata_i[15:0]),
        .ctrl_o(rx_ctrl),
        .pw_o(rx_pw),
        .rev_o(rx_rev),
        .done_o(rx_done)
    );

    dsfp_pw_cmp u_cmp (
        .user_pw_i(user_pw_o),
        .master_pw_i(master_pw_o),
        .user_valid_i(user_valid_q),
        .master_valid_i(master_valid_q),
        .level_max_i(level_max_o),
        .cand_pw_i(cred_pw_i),
        .sel_master_i(cred_sel_master_i),
        .match_o(cmp_match)
    );
endmodule

// ### shared/dsfp_regs.vh
// What this block does
// - Opcode F5h freezes security at once, with no data phase.
// - After freeze completes, commands altering lock configuration are refused.
// - Frozen state survives hard reset and everything except power removal.
// - While frozen, set password, unlock, disable password and erase unit abort.
// - Opcode F1h stores a user or master password, maybe enabling lock.
// - User password set does not lock now; lock applies after next hard reset or power-on.
// - Master password set stores it but never causes a lock after reset.
// - Set password takes exactly one 256-word sector, then acts on it.
// - Parameter word 0 bit 0 selects user (0) or master (1) password.
// - Parameter word 0 bit 8 selects high (0) or maximum (1) level.
// - Password is words 1 to 16; all 32 bytes are compared later.
// - Word 17 is master revision code, used only for master; reported out.
// - Revision code stored only when 0001h..FFFEh; otherwise old code kept.
// - User at high level: save user password, lock from next hard reset or power-on.
// - Master at either level: store master only, lock enable unchanged.
// - User at maximum level: save user, lock later, master never unlocks.
// - At maximum level only the user password passes the check; erase prep and erase unit abort.
// - At high level the master password is accepted as unlock credential.
`ifndef DSFP_REGS_VH
`define DSFP_REGS_VH

// Register byte offsets
`define DSFP_OFS_DATA 6'h00
`define DSFP_OFS_ERR 6'h04
`define DSFP_OFS_DEVH 6'h18
`define DSFP_OFS_CMD 6'h1C
`define DSFP_OFS_SECST 6'h20
`define DSFP_OFS_REV 6'h24

// Opcodes
`define DSFP_OP_SETPW 8'hF1
`define DSFP_OP_UNLOCK 8'hF2
`define DSFP_OP_ERPREP 8'hF3
`define DSFP_OP_ERUNIT 8'hF4
`define DSFP_OP_FREEZE 8'hF5
`define DSFP_OP_DISPW 8'hF6

// Status and error values
`define DSFP_ST_RST 8'h40
`define DSFP_ST_OK 8'h40
`define DSFP_ST_DRQ 8'h48
`define DSFP_ST_BSY 8'h80
`define DSFP_ST_ABORT 8'h41
`define DSFP_ERR_NONE 8'h00
`define DSFP_ERR_ABT 8'h04

// Parameter sector layout
`define DSFP_CTL_SEL_BIT 0
`define DSFP_CTL_LVL_BIT 8
`define DSFP_DEVH_DEV_BIT 4
`define DSFP_WORD_LAST 8'hFF
`define DSFP_WORD_REV 8'h11
`define DSFP_REV_MIN 16'h0001
`define DSFP_REV_MAX 16'hFFFE
`define DSFP_REV_RST 16'h0000

`endif

// ### rtl/dsfp_sector_rx.v
`timescale 1ns/1ns
`include "dsfp_regs.vh"
module dsfp_sector_rx (
    // Clock and reset
    input wire ref_clk_i,
    input wire reset_n_i,
    // Word stream
    input wire active_i,
    input wire wr_i,
    input wire [15:0] data_i,
    // Captured fields
    output reg [15:0] ctrl_o,
    output wire [255:0] pw_o,
    output reg [15:0] rev_o,
    output reg done_o
);
    reg [7:0] cnt_q;
    reg [15:0] pw_word_q [0:15];

    // Counter restarts whenever no transfer runs
    always @(posedge ref_clk_i) begin
        if (!reset_n_i || !active_i) begin
            cnt_q <= 8'h00;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (wr_i) begin
                cnt_q <= cnt_q + 8'h01;
                done_o <= (cnt_q == `DSFP_WORD_LAST);
            end
        end
    end

    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            ctrl_o <= 16'h0000;
            rev_o <= 16'h0000;
        end else if (active_i && wr_i) begin
            if (cnt_q == 8'h00) begin
                ctrl_o <= data_i;
            end
            if (cnt_q == `DSFP_WORD_REV) begin
                rev_o <= data_i;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_pw
            always @(posedge ref_clk_i) begin
                if (!reset_n_i) begin
                    pw_word_q[gi] <= 16'h0000;
                end else if (active_i && wr_i && cnt_q == gi + 1) begin
                    pw_word_q[gi] <= data_i;
                end
            end
            assign pw_o[gi*16 +: 16] = pw_word_q[gi];
        end
    endgenerate
endmodule

// ### rtl/dsfp_pw_cmp.v
`timescale 1ns/1ns
module dsfp_pw_cmp (
    // Stored credentials
    input wire [255:0] user_pw_i,
    input wire [255:0] master_pw_i,
    input wire user_valid_i,
    input wire master_valid_i,
    input wire level_max_i,
    // Candidate
    input wire [255:0] cand_pw_i,
    input wire sel_master_i,
    // Verdict
    output wire match_o
);
    // Full 256-bit equality, no byte is masked
    wire user_eq = user_valid_i && (cand_pw_i == user_pw_i);
    wire master_eq = master_valid_i && (cand_pw_i == master_pw_i);

    // Master counts only at high level
    assign match_o = sel_master_i ? (master_eq && !level_max_i) : user_eq;
endmodule

// ### verification/dsfp_chk_sva.sv
`timescale 1ns/1ns
`include "dsfp_regs.vh"
module dsfp_chk #(
    parameter DEV_SEL = 1'b0
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire reset_n_i,
    // Bus
    input wire [5:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    input wire avs_waitrequest_o,
    // Security state
    input wire hard_reset_i,
    input wire frozen_o,
    input wire lock_enabled_o,
    input wire locked_o,
    input wire cred_check_i,
    input wire cred_done_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    wire req = avs_read_i | avs_write_i;
    reg dev_q;
    // Mirror of the device select bit; a command for the other drive is ignored
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            dev_q <= 1'b0;
        end else if (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] &&
            avs_address_i == `DSFP_OFS_DEVH) begin
            dev_q <= avs_writedata_i[`DSFP_DEVH_DEV_BIT];
        end
    end
    wire fz = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && dev_q == DEV_SEL
        && avs_address_i == `DSFP_OFS_CMD && avs_writedata_i[7:0] == `DSFP_OP_FREEZE;
    ////////////////////////////////////////////////////////////////////////////////
    AST_ACK_NEXT: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("no ack one cycle after request");
    AST_ACK_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("ack longer than one cycle");
    AST_IDLE_WAIT: assert property (!req |-> avs_waitrequest_o)
        else $error("ack without request");
    AST_FREEZE: assert property (fz |=> frozen_o)
        else $error("freeze not applied");
    AST_FROZEN_HOLD: assert property (frozen_o |=> frozen_o)
        else $error("frozen state lost");
    AST_FROZEN_LOCK: assert property (frozen_o |=> $stable(lock_enabled_o))
        else $error("lock enable changed while frozen");
    AST_HARD_LOCK: assert property (hard_reset_i |=> locked_o == $past(lock_enabled_o))
        else $error("lock after hard reset wrong");
    // Only resets may move the lock; a set command must not
    AST_LOCK_STEADY: assert property ($past(reset_n_i, 2) && !$past(hard_reset_i)
        |-> $stable(locked_o))
        else $error("lock changed without reset");
    AST_CRED_ANS: assert property (cred_check_i |=> cred_done_o)
        else $error("credential answer missing");
    AST_CRED_CAUSE: assert property (cred_done_o |-> $past(cred_check_i))
        else $error("credential answer unrequested");
    COV_FREEZE: cover property (fz);
    COV_CRED: cover property (cred_done_o);
    COV_HARD_FROZEN: cover property (hard_reset_i && frozen_o);
endmodule
bind dsfp_top dsfp_chk #(.DEV_SEL(DEV_SEL)) u_chk (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_waitrequest_o(avs_waitrequest_o),
    .hard_reset_i(hard_reset_i), .frozen_o(frozen_o), .lock_enabled_o(lock_enabled_o),
    .locked_o(locked_o), .cred_check_i(cred_check_i), .cred_done_o(cred_done_o));

// ### verification/dsfp_nv_model.sv
`timescale 1ns/1ns
module dsfp_nv_model (
    // Clock and power
    input wire ref_clk_i,
    input wire reset_n_i,
    // Lock enable to keep
    input wire lock_enabled_i,
    output reg nv_lock_enabled_o
);
    reg armed_q;
    initial nv_lock_enabled_o = 1'b0;
    initial armed_q = 1'b0;
    // Kept through power removal, so nothing is taken while reset is low
    // First cycle after release skipped: the block still shows its reset value
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= 1'b1;
            if (armed_q) begin
                nv_lock_enabled_o <= lock_enabled_i;
            end
        end
    end
endmodule

// ### verification/tb.sv
`timescale 1ns/1ns
`include "dsfp_regs.vh"
module tb;
    localparam logic [255:0] PA = {8{32'h13579BDF}};
    localparam logic [255:0] PB = {8{32'h2468ACE0}};
    localparam logic [255:0] PC = {8{32'hF00D4321}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] adr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic hrst = 1'b0;
    logic cchk = 1'b0;
    logic csel = 1'b0;
    logic [255:0] cpw = 256'h0;
    logic [31:0] rdat, r;
    logic wreq, nv, frz, len, lck, lmax, cdone, cok;
    logic [15:0] mrev;
    logic [255:0] upw, mpw;
    logic [15:0] rvs [3] = '{16'hFFFF, 16'h0000, 16'hFFFE};
    logic [15:0] rex [3] = '{16'h1234, 16'h1234, 16'hFFFE};
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    dsfp_top u_dut (.ref_clk_i(clk), .reset_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .nv_lock_enabled_i(nv),
        .hard_reset_i(hrst), .frozen_o(frz), .lock_enabled_o(len), .locked_o(lck),
        .level_max_o(lmax), .master_rev_o(mrev), .user_pw_o(upw), .master_pw_o(mpw),
        .cred_check_i(cchk), .cred_sel_master_i(csel), .cred_pw_i(cpw),
        .cred_done_o(cdone), .cred_ok_o(cok));
    dsfp_nv_model u_nv (.ref_clk_i(clk), .reset_n_i(rst_n), .lock_enabled_i(len),
        .nv_lock_enabled_o(nv));
    initial begin
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task stop_test;
        if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Sector transfers dominate the run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt = error_cnt + 1;
            stop_test;
        end
    end
    task chk(input string nm, input logic [255:0] e, input logic [255:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a; wr <= w; rd <= !w; wd <= d;
        do @(posedge clk); while (wreq !== 1'b0);
        r = rdat;
        rd <= 1'b0; wr <= 1'b0;
    endtask
    task sector(input logic [15:0] ctl, input logic [255:0] pw, input logic [15:0] rv);
        int i;
        logic [15:0] w16;
        bus(1, `DSFP_OFS_DEVH, 32'hA0);
        bus(1, `DSFP_OFS_CMD, `DSFP_OP_SETPW);
        for (i = 0; i < 256; i++) begin
            w16 = (i == 0) ? ctl : (i == 17) ? rv : 16'h0;
            if (i > 0 && i < 17) w16 = pw[16*i-16 +: 16];
            bus(1, `DSFP_OFS_DATA, {16'h0, w16});
        end
        repeat (3) @(posedge clk);
        bus(0, `DSFP_OFS_CMD, 0);
        chk("status", `DSFP_ST_OK, r);
    endtask
    task cred(input logic s, input logic [255:0] p, input logic e);
        @(posedge clk);
        cchk <= 1'b1; csel <= s; cpw <= p;
        @(posedge clk);
        cchk <= 1'b0;
        @(posedge clk);
        chk("cred_done", 1'b1, cdone);
        chk("cred_ok", e, cok);
    endtask
    task pwr;
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    task hpulse;
        @(posedge clk);
        hrst <= 1'b1;
        @(posedge clk);
        hrst <= 1'b0;
        @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pwr();
        bus(0, `DSFP_OFS_CMD, 0); chk("status", `DSFP_ST_RST, r);
        bus(0, `DSFP_OFS_ERR, 0); chk("error", `DSFP_ERR_NONE, r);
        bus(0, 6'h3C, 0); chk("unmapped", 0, r);
        // Master password and revision boundaries
        sector(16'h0001, PA, 16'h1234); chk("mpw", PA, mpw);
        chk("rev", 16'h1234, mrev);
        for (int k = 0; k < 3; k++) begin
            sector(16'h0101, PA, rvs[k]); chk("rev", rex[k], mrev);
        end
        chk("lock_en", 1'b0, len);
        bus(0, `DSFP_OFS_REV, 0); chk("rev_reg", 16'hFFFE, r);
        hpulse(); chk("locked", 1'b0, lck);
        // User password at high level
        sector(16'h0000, PB, 16'h5555); chk("upw", PB, upw);
        chk("rev", 16'hFFFE, mrev);
        chk("lock_en", 1'b1, len);
        chk("locked", 1'b0, lck);
        chk("lmax", 1'b0, lmax);
        cred(1'b1, PA, 1'b1);
        cred(1'b0, PB ^ (256'h1 << 255), 1'b0);
        cred(1'b0, PB, 1'b1);
        // User password at maximum level
        sector(16'h0100, PC, 16'h0000); chk("lmax", 1'b1, lmax);
        chk("mpw", PA, mpw);
        cred(1'b1, PA, 1'b0);
        // Command for the other drive is ignored
        bus(1, `DSFP_OFS_DEVH, 32'hB0);
        bus(0, `DSFP_OFS_DEVH, 0); chk("devh", 8'hB0, r);
        bus(1, `DSFP_OFS_CMD, `DSFP_OP_FREEZE);
        @(posedge clk); chk("frozen", 1'b0, frz);
        // Freeze, then refused set password
        bus(1, `DSFP_OFS_DEVH, 32'hA0);
        bus(1, `DSFP_OFS_CMD, `DSFP_OP_FREEZE);
        @(posedge clk); chk("frozen", 1'b1, frz);
        bus(0, `DSFP_OFS_CMD, 0); chk("status", `DSFP_ST_OK, r);
        bus(1, `DSFP_OFS_CMD, `DSFP_OP_SETPW);
        repeat (2) @(posedge clk);
        bus(0, `DSFP_OFS_CMD, 0); chk("status", `DSFP_ST_ABORT, r);
        bus(0, `DSFP_OFS_ERR, 0); chk("error", `DSFP_ERR_ABT, r);
        bus(1, `DSFP_OFS_CMD, `DSFP_OP_UNLOCK);
        bus(0, `DSFP_OFS_CMD, 0); chk("status", `DSFP_ST_ABORT, r);
        bus(0, `DSFP_OFS_SECST, 0); chk("secstate", 32'h0000_003B, r);
        chk("upw", PC, upw);
        hpulse(); chk("frozen", 1'b1, frz);
        // Power cycle clears freeze and applies lock
        pwr(); chk("frozen", 1'b0, frz);
        chk("locked", 1'b1, lck);
        bus(1, `DSFP_OFS_DEVH, 32'hA0);
        bus(1, `DSFP_OFS_CMD, `DSFP_OP_SETPW);
        bus(0, `DSFP_OFS_CMD, 0); chk("status", `DSFP_ST_ABORT, r);
        stop_test;
    end
endmodule
